// *** rtl/gsp_pkg.sv ***
// package: register map, field positions, reset values and shared types of the strap/status block
package gsp_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_IRQCFG = 8'h04;
   localparam logic [7:0] OFF_GPIO   = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_IRQST  = 8'h10;
   localparam logic [7:0] OFF_IRQMSK = 8'h14;

   // control register fields
   localparam int CTRL_EXTSW  = 0;
   localparam int CTRL_RATE   = 1;
   localparam int CTRL_DIG1   = 2;
   localparam int CTRL_DIG2   = 3;
   localparam int CTRL_SRFPIN = 4;
   localparam int CTRL_LOCKEN = 5;

   // irq pin config fields
   localparam int ICFG_LOSSEL = 0;
   localparam int ICFG_POL_HI = 1;
   localparam int ICFG_OPEN_D = 2;
   localparam int ICFG_GPO    = 3;
   localparam int ICFG_GPOVAL = 4;

   // gpio register fields
   localparam int GPIO_DIR    = 0;
   localparam int GPIO_OUT    = 1;
   localparam int GPIO_STATE  = 2;

   // status / event fields
   localparam int ST_REFFAIL  = 0;
   localparam int ST_LOCK     = 1;
   localparam int ST_ACTIVE   = 2;
   localparam int ST_PAIR     = 3;
   localparam int EV_FAIL_SET = 0;
   localparam int EV_LOCK_CHG = 1;
   localparam int EV_ACT_LOSS = 2;
   localparam int EV_W        = 3;

   // reset values
   localparam logic [4:0] IRQCFG_RST = 5'h00;
   localparam logic [1:0] GPIO_RST   = 2'h0;
   localparam logic [EV_W-1:0] MSK_RST = 3'h0;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // write-side phases of the bus slave, gray coded
   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_RESP = 2'b01
   } gsp_wr_state_t;

   // status from the reference monitor and dpll
   typedef struct packed {
      logic ref_active;
      logic ref_freq_ok;
      logic dpll_locked;
   } gsp_mon_t;

   // reference pair steering
   typedef struct packed {
      logic ext_switch_en;
      logic pair_46;
   } gsp_sel_t;

endpackage

// *** rtl/gsp_sync2.sv ***
// module: two flip-flop synchroniser for level inputs
`timescale 1ns/100ps
module gsp_sync2 #(
   parameter int W = 2
) (
   // clock
   input  wire logic         aclk,
   // level in and synchronised level out
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // no reset: the chain keeps sampling through reset so straps are settled at release
   always_ff @(posedge aclk)
   begin
      meta_q <= din;
      sync_q <= meta_q;
   end

   assign dout = sync_q;
endmodule

// *** rtl/gsp_top.sv ***
// module: global strap capture, gpio 4, status pins and irq/los output with an axi4-lite slave
//
// Summary of operation
// RULE1 - while aresetn is low every flip-flop except the strap synchroniser returns to its default and stays there.
// RULE2 - the board keeps aresetn low for at least two clock cycles once the clock is valid.
// RULE3 - on reset release the source-select pin level becomes the external switching bit.
// RULE4 - with external switching on, the source-select pin picks pair 3/5 (low) or 4/6 (high).
// RULE5 - on reset release the rate strap loads the rate family bit and both output family bits.
// RULE6 - after reset the strap pin is general io 4 with direction, out value and pin state.
// RULE7 - the ref-fail pin follows the fail status when enabled, otherwise low.
// RULE8 - the lock pin shows the main dpll lock state when enabled, otherwise low.
// RULE9 - the shared pin is the interrupt request when the select is 0, missing-reference when 1.
// RULE10 - in interrupt mode config sets polarity, push-pull or open drain, or plain output.
// RULE11 - in missing-reference mode the pin shows the live activity monitor, not latched.
// RULE12 - the fail status is set or cleared from the selected reference activity and frequency.
// RULE13 - straps pass a synchroniser so captured defaults are stable right after reset release.
`timescale 1ns/100ps
module gsp_top (
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // axi4-lite write address and data
   input  wire logic [7:0]       s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]       s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   // strap and gpio pins
   input  wire logic             fast_source_select_pin,
   input  wire logic             rate_family_strap_i,
   output logic                  general_io_4_o,
   output logic                  general_io_4_oe_n,
   // reference monitor and dpll status
   input  wire gsp_pkg::gsp_mon_t mon,
   // status outputs
   output gsp_pkg::gsp_sel_t     ref_pair_sel,
   output logic                  selected_ref_fail_pin,
   output logic                  dpll_locked_pin,
   output logic                  irq_los_o,
   output logic                  irq_los_oe_n,
   output logic                  irq_o
);
   logic [1:0] pins_s;
   logic       srcsel_s;
   logic       strap_s;
   logic       in_rst_q;

   // strap sampling through the synchroniser [RULE13]
   gsp_sync2 #(.W(2)) u_sync (
      .aclk    (aclk),
      .din     ({fast_source_select_pin, rate_family_strap_i}),
      .dout    (pins_s)
   );
   assign srcsel_s = pins_s[1];
   assign strap_s  = pins_s[0];

   // register state
   logic [5:0]            ctrl_q, ctrl_d;
   logic [4:0]            icfg_q, icfg_d;
   logic [1:0]            gpio_q, gpio_d;
   logic [gsp_pkg::EV_W-1:0] ev_q, ev_d, msk_q, msk_d;
   logic                  fail_q, fail_d, lock_prev_q, act_prev_q;

   // bus state
   gsp_pkg::gsp_wr_state_t wst_q, wst_d;
   logic       aw_got_q, aw_got_d, w_got_q, w_got_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [1:0] bresp_q, bresp_d;
   logic       rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;

   function automatic logic known_addr(input logic [7:0] a);
      if (a == gsp_pkg::OFF_CTRL) known_addr = 1'b1;
      else if (a == gsp_pkg::OFF_IRQCFG) known_addr = 1'b1;
      else if (a == gsp_pkg::OFF_GPIO) known_addr = 1'b1;
      else if (a == gsp_pkg::OFF_STATUS) known_addr = 1'b1;
      else if (a == gsp_pkg::OFF_IRQST) known_addr = 1'b1;
      else if (a == gsp_pkg::OFF_IRQMSK) known_addr = 1'b1;
      else known_addr = 1'b0;
   endfunction

   logic       wr_fire;
   logic [gsp_pkg::EV_W-1:0] ev_set;
   logic       fail_now;
   logic       irq_active;

   // fail from activity and frequency of the selected reference [RULE12]
   assign fail_now = !(mon.ref_active && mon.ref_freq_ok);
   // no lock event in the release cycle: lock_prev_q still holds its reset value
   assign ev_set = {act_prev_q && !mon.ref_active,
                    !in_rst_q && (lock_prev_q != mon.dpll_locked),
                    fail_now && !fail_q};
   assign wr_fire = (wst_q == gsp_pkg::WR_IDLE) && aw_got_q && w_got_q;

   always_comb
   begin
      wst_d    = wst_q;
      aw_got_d = aw_got_q;
      w_got_d  = w_got_q;
      awaddr_d = awaddr_q;
      wdata_d  = wdata_q;
      bresp_d  = bresp_q;
      ctrl_d   = ctrl_q;
      icfg_d   = icfg_q;
      gpio_d   = gpio_q;
      msk_d    = msk_q;
      // set wins over a simultaneous write-one-to-clear
      ev_d     = ev_q | ev_set;
      fail_d   = fail_now;
      if (in_rst_q)
      begin
         // first cycle after release: load strap defaults [RULE3] [RULE5]
         ctrl_d[gsp_pkg::CTRL_EXTSW] = srcsel_s;
         ctrl_d[gsp_pkg::CTRL_RATE]  = strap_s;
         ctrl_d[gsp_pkg::CTRL_DIG1]  = strap_s;
         ctrl_d[gsp_pkg::CTRL_DIG2]  = strap_s;
      end
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_got_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_got_d = 1'b1;
         wdata_d = s_axi_wdata;
      end
      case (wst_q)
         gsp_pkg::WR_IDLE:
         begin
            if (wr_fire)
            begin
               wst_d    = gsp_pkg::WR_RESP;
               aw_got_d = 1'b0;
               w_got_d  = 1'b0;
               bresp_d  = known_addr(awaddr_q) ? gsp_pkg::RESP_OKAY : gsp_pkg::RESP_SLVERR;
               if (awaddr_q == gsp_pkg::OFF_CTRL)
                  ctrl_d = wdata_q[5:0];
               else if (awaddr_q == gsp_pkg::OFF_IRQCFG)
                  icfg_d = wdata_q[4:0];
               else if (awaddr_q == gsp_pkg::OFF_GPIO)
                  gpio_d = wdata_q[1:0];
               else if (awaddr_q == gsp_pkg::OFF_IRQST)
                  ev_d = (ev_q & ~wdata_q[gsp_pkg::EV_W-1:0]) | ev_set;
               else if (awaddr_q == gsp_pkg::OFF_IRQMSK)
                  msk_d = wdata_q[gsp_pkg::EV_W-1:0];
            end
         end
         gsp_pkg::WR_RESP:
         begin
            if (s_axi_bready)
               wst_d = gsp_pkg::WR_IDLE;
         end
         default:
            wst_d = gsp_pkg::WR_IDLE;
      endcase
   end

   // read path: one read at a time, data from a register
   always_comb
   begin
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (rvalid_q && s_axi_rready)
         rvalid_d = 1'b0;
      else if (!rvalid_q && s_axi_arvalid && s_axi_arready)
      begin
         rvalid_d = 1'b1;
         rresp_d  = gsp_pkg::RESP_OKAY;
         rdata_d  = 32'h0000_0000;
         if (s_axi_araddr == gsp_pkg::OFF_CTRL)
            rdata_d[5:0] = ctrl_q;
         else if (s_axi_araddr == gsp_pkg::OFF_IRQCFG)
            rdata_d[4:0] = icfg_q;
         else if (s_axi_araddr == gsp_pkg::OFF_GPIO)
            rdata_d[2:0] = {strap_s, gpio_q}; // pin state [RULE6]
         else if (s_axi_araddr == gsp_pkg::OFF_STATUS)
            rdata_d[3:0] = {ref_pair_sel.pair_46, mon.ref_active, mon.dpll_locked, fail_q};
         else if (s_axi_araddr == gsp_pkg::OFF_IRQST)
            rdata_d[gsp_pkg::EV_W-1:0] = ev_q;
         else if (s_axi_araddr == gsp_pkg::OFF_IRQMSK)
            rdata_d[gsp_pkg::EV_W-1:0] = msk_q;
         else
            rresp_d = gsp_pkg::RESP_SLVERR;
      end
   end

   assign irq_active = |(ev_q & msk_q);

   // all state takes its reset value synchronously while reset is low, in_rst_q sets and the rest clear [RULE1]
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         in_rst_q    <= 1'b1;
         ctrl_q      <= 6'h00;
         icfg_q      <= gsp_pkg::IRQCFG_RST;
         gpio_q      <= gsp_pkg::GPIO_RST;
         ev_q        <= 3'h0;
         msk_q       <= gsp_pkg::MSK_RST;
         fail_q      <= 1'b0;
         lock_prev_q <= 1'b0;
         act_prev_q  <= 1'b0;
         wst_q       <= gsp_pkg::WR_IDLE;
         aw_got_q    <= 1'b0;
         w_got_q     <= 1'b0;
         awaddr_q    <= 8'h00;
         wdata_q     <= 32'h0000_0000;
         bresp_q     <= 2'h0;
         rvalid_q    <= 1'b0;
         rdata_q     <= 32'h0000_0000;
         rresp_q     <= 2'h0;
      end
      else
      begin
         in_rst_q    <= 1'b0;
         ctrl_q      <= ctrl_d;
         icfg_q      <= icfg_d;
         gpio_q      <= gpio_d;
         ev_q        <= ev_d;
         msk_q       <= msk_d;
         fail_q      <= fail_d;
         lock_prev_q <= mon.dpll_locked;
         act_prev_q  <= mon.ref_active;
         wst_q       <= wst_d;
         aw_got_q    <= aw_got_d;
         w_got_q     <= w_got_d;
         awaddr_q    <= awaddr_d;
         wdata_q     <= wdata_d;
         bresp_q     <= bresp_d;
         rvalid_q    <= rvalid_d;
         rdata_q     <= rdata_d;
         rresp_q     <= rresp_d;
      end
   end

   // registered pin outputs from next-state values: in step with the registers, one cycle behind live inputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready         <= 1'b0;
         s_axi_wready          <= 1'b0;
         s_axi_bvalid          <= 1'b0;
         s_axi_bresp           <= 2'h0;
         s_axi_arready         <= 1'b0;
         s_axi_rvalid          <= 1'b0;
         s_axi_rdata           <= 32'h0000_0000;
         s_axi_rresp           <= 2'h0;
         general_io_4_o        <= 1'b0;
         general_io_4_oe_n     <= 1'b1;
         ref_pair_sel          <= '0;
         selected_ref_fail_pin <= 1'b0;
         dpll_locked_pin       <= 1'b0;
         irq_los_o             <= 1'b0;
         irq_los_oe_n          <= 1'b1;
         irq_o                 <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_got_d && wst_d == gsp_pkg::WR_IDLE && !s_axi_awready;
         s_axi_wready  <= !w_got_d && wst_d == gsp_pkg::WR_IDLE && !s_axi_wready;
         s_axi_bvalid  <= wst_d == gsp_pkg::WR_RESP;
         s_axi_bresp   <= bresp_d;
         s_axi_arready <= !rvalid_d && !s_axi_arready;
         s_axi_rvalid  <= rvalid_d;
         s_axi_rdata   <= rdata_d;
         s_axi_rresp   <= rresp_d;
         // gpio 4 drive, open only when configured as output [RULE6]
         general_io_4_o    <= gpio_d[gsp_pkg::GPIO_OUT];
         general_io_4_oe_n <= !gpio_d[gsp_pkg::GPIO_DIR];
         ref_pair_sel.ext_switch_en <= ctrl_d[gsp_pkg::CTRL_EXTSW];
         ref_pair_sel.pair_46 <= ctrl_d[gsp_pkg::CTRL_EXTSW] && srcsel_s; // [RULE4]
         selected_ref_fail_pin <= ctrl_d[gsp_pkg::CTRL_SRFPIN] && fail_d; // [RULE7]
         dpll_locked_pin <= ctrl_d[gsp_pkg::CTRL_LOCKEN] && mon.dpll_locked; // [RULE8]
         irq_o <= |(ev_d & msk_d);
         if (icfg_d[gsp_pkg::ICFG_LOSSEL])
         begin
            // live monitor, no latching [RULE9] [RULE11]
            irq_los_o    <= !mon.ref_active;
            irq_los_oe_n <= 1'b0;
         end
         else if (icfg_d[gsp_pkg::ICFG_GPO])
         begin
            irq_los_o    <= icfg_d[gsp_pkg::ICFG_GPOVAL]; // [RULE10]
            irq_los_oe_n <= 1'b0;
         end
         else
         begin
            // polarity then drive style [RULE9] [RULE10]
            irq_los_o <= (|(ev_d & msk_d)) == icfg_d[gsp_pkg::ICFG_POL_HI];
            irq_los_oe_n <= icfg_d[gsp_pkg::ICFG_OPEN_D] &&
                            ((|(ev_d & msk_d)) == icfg_d[gsp_pkg::ICFG_POL_HI]);
         end
      end
   end

   // checks
   a_reset_clear: assert property (@(posedge aclk) !aresetn |=> !irq_o && !dpll_locked_pin
      && !selected_ref_fail_pin) else $error("outputs not cleared by reset"); // [RULE1]
   a_strap_extsw: assert property (@(posedge aclk) disable iff (!aresetn)
      in_rst_q |=> ctrl_q[gsp_pkg::CTRL_EXTSW] == $past(srcsel_s))
      else $error("switch mode not strapped"); // [RULE3]
   a_strap_rate: assert property (@(posedge aclk) disable iff (!aresetn)
      in_rst_q |=> ctrl_q[3:1] == {3{$past(strap_s)}})
      else $error("rate family not strapped"); // [RULE5]
   a_pair_select: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl_d[gsp_pkg::CTRL_EXTSW] |=> !ref_pair_sel.pair_46)
      else $error("pair switched while disabled"); // [RULE4]
   a_fail_pin: assert property (@(posedge aclk) disable iff (!aresetn)
      selected_ref_fail_pin |-> ctrl_q[gsp_pkg::CTRL_SRFPIN] && fail_q)
      else $error("fail pin without cause"); // [RULE7]
   a_lock_pin: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 dpll_locked_pin == (ctrl_q[gsp_pkg::CTRL_LOCKEN] && $past(mon.dpll_locked)))
      else $error("lock pin mismatch"); // [RULE8]
   a_los_live: assert property (@(posedge aclk) disable iff (!aresetn)
      icfg_q[gsp_pkg::ICFG_LOSSEL] && $stable(icfg_q) |-> irq_los_o == !$past(mon.ref_active))
      else $error("los output lagging"); // [RULE11]
   a_fail_status: assert property (@(posedge aclk) disable iff (!aresetn)
      !mon.ref_active |=> fail_q) else $error("fail status not set"); // [RULE12]
   a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 irq_o == |(ev_q & msk_q)) else $error("irq level mismatch"); // [RULE10]
   c_write_done: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
   c_read_done: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
   c_irq_raise: cover property (@(posedge aclk) $rose(irq_o));
   c_los_mode: cover property (@(posedge aclk) icfg_q[gsp_pkg::ICFG_LOSSEL] && !irq_los_o);
endmodule

// *** verif/gsp_board_model.sv ***
// board-side model: strap drive, pull-down on gpio 4 and pull-up on the irq/los pin
`timescale 1ns/100ps
module gsp_board_model (
   // board strap drive
   input  wire logic strap_drive_en,
   input  wire logic strap_level,
   // device pin drivers
   input  wire logic gpio_o,
   input  wire logic gpio_oe_n,
   input  wire logic irq_los_o,
   input  wire logic irq_los_oe_n,
   // resolved pin levels
   output logic      gpio_wire,
   output logic      irq_wire
);
   // a released pin takes the board strap level or falls to its pull level, never keeps its last driven value
   always_comb
   begin
      if (!gpio_oe_n)
         gpio_wire = gpio_o;
      else if (strap_drive_en)
         gpio_wire = strap_level;
      else
         gpio_wire = 1'b0;
   end
   // board pull-up makes open drain readable
   assign irq_wire = irq_los_oe_n ? 1'b1 : irq_los_o;
endmodule

// *** verif/gsp_top_bench.sv ***
// testbench: bus tasks and pin scenarios for the strap/status block
`timescale 1ns/100ps
module gsp_top_bench;
   logic             aclk = 1'b0;
   logic             aresetn = 1'b0;
   logic [7:0]       awaddr = 8'h00;
   logic             awvalid = 1'b0;
   logic             awready;
   logic [31:0]      wdata = 32'h0000_0000;
   logic             wvalid = 1'b0;
   logic             wready;
   logic [1:0]       bresp;
   logic             bvalid;
   logic             bready = 1'b0;
   logic [7:0]       araddr = 8'h00;
   logic             arvalid = 1'b0;
   logic             arready;
   logic [31:0]      rdata;
   logic [1:0]       rresp;
   logic             rvalid;
   logic             rready = 1'b0;
   logic             fss = 1'b0;
   logic             strap_en = 1'b1;
   logic             strap_lvl = 1'b0;
   gsp_pkg::gsp_mon_t mon = 3'h7;
   gsp_pkg::gsp_sel_t pair_sel;
   logic             gpio_o;
   logic             gpio_oe_n;
   logic             gpio_wire;
   logic             fail_pin;
   logic             lock_pin;
   logic             irq_los_o;
   logic             irq_los_oe_n;
   logic             irq_wire;
   logic             irq_o;
   int               mismatches = 0;
   int               tests_run = 0;
   logic [7:0]       cfg_tab [5] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h18};
   logic [1:0]       pin_tab [5] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h1};

   always #5 aclk = ~aclk;

   gsp_top gsp_top_inst (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .fast_source_select_pin(fss), .rate_family_strap_i(gpio_wire),
      .general_io_4_o(gpio_o), .general_io_4_oe_n(gpio_oe_n), .mon(mon),
      .ref_pair_sel(pair_sel), .selected_ref_fail_pin(fail_pin), .dpll_locked_pin(lock_pin),
      .irq_los_o(irq_los_o), .irq_los_oe_n(irq_los_oe_n), .irq_o(irq_o));

   gsp_board_model gsp_board_model_inst (
      .strap_drive_en(strap_en), .strap_level(strap_lvl), .gpio_o(gpio_o),
      .gpio_oe_n(gpio_oe_n), .irq_los_o(irq_los_o), .irq_los_oe_n(irq_los_oe_n),
      .gpio_wire(gpio_wire), .irq_wire(irq_wire));

   task automatic test_done;
      if (mismatches == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h", $time, msg, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1)
         begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1)
         begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk(bresp, er, "write response");
   endtask

   // read and compare the masked word
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input logic [1:0] er);
      logic ar_ok;
      logic r_ok;
      ar_ok = 1'b0;
      r_ok = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!(ar_ok && r_ok))
      begin
         @(posedge aclk);
         if (!ar_ok && arready === 1'b1)
         begin
            ar_ok = 1'b1;
            arvalid <= 1'b0;
         end
         if (!r_ok && rvalid === 1'b1)
         begin
            r_ok = 1'b1;
            rready <= 1'b0;
            chk(rresp, er, "read response");
            chk(rdata & m, e, "read data");
         end
      end
   endtask

   // straps held stable across the release so the synchroniser flushes them
   task automatic do_reset(input logic v);
      @(posedge aclk);
      aresetn <= 1'b0;
      fss <= v;
      strap_en <= 1'b1;
      strap_lvl <= v;
      cyc(8);
      chk({fail_pin, lock_pin, irq_o, gpio_oe_n}, 4'h1, "pins in reset");
      aresetn <= 1'b1;
      cyc(3);
      strap_en <= 1'b0;
   endtask

   task automatic gp(input logic dir, input logic out, input logic sen, input logic st);
      strap_en <= sen;
      strap_lvl <= 1'b1;
      wr(gsp_pkg::OFF_GPIO, {30'h0, out, dir}, gsp_pkg::RESP_OKAY);
      cyc(4);
      chk({gpio_oe_n, gpio_wire}, {!dir, st}, "gpio pin");
      rc(gsp_pkg::OFF_GPIO, 32'h0000_0004, {29'h0, st, 2'h0}, gsp_pkg::RESP_OKAY);
   endtask

   initial
   begin
      for (int s = 0; s < 2; s++)
      begin
         do_reset(s[0]);
         rc(gsp_pkg::OFF_CTRL, 32'h0000_000F, s[0] ? 32'h0000_000F : 32'h0, 2'h0);
         rc(gsp_pkg::OFF_IRQCFG, 32'h0000_001F, 32'h0000_0000, 2'h0);
         rc(gsp_pkg::OFF_IRQMSK, 32'h0000_0007, 32'h0000_0000, 2'h0);
         rc(gsp_pkg::OFF_IRQST, 32'h0000_0007, 32'h0000_0000, 2'h0);
         if (s == 0)
            wr(gsp_pkg::OFF_IRQCFG, 32'h0000_001F, gsp_pkg::RESP_OKAY);
      end
      // pair steering while external switching is on, forced off afterwards
      for (int p = 0; p < 2; p++)
      begin
         fss <= p[0];
         cyc(5);
         chk(pair_sel, {1'b1, p[0]}, "pair select");
      end
      wr(gsp_pkg::OFF_CTRL, 32'h0000_0000, gsp_pkg::RESP_OKAY);
      cyc(4);
      chk(pair_sel, 2'h0, "pair select off");
      gp(1'b1, 1'b1, 1'b0, 1'b1);
      gp(1'b1, 1'b0, 1'b1, 1'b0);
      gp(1'b0, 1'b0, 1'b1, 1'b1);
      gp(1'b0, 1'b0, 1'b0, 1'b0);
      // fail and lock pins enabled
      wr(gsp_pkg::OFF_CTRL, 32'h0000_0031, gsp_pkg::RESP_OKAY);
      mon <= 3'h2;
      cyc(4);
      chk({fail_pin, lock_pin}, 2'h2, "no activity");
      rc(gsp_pkg::OFF_STATUS, 32'h0000_0007, 32'h0000_0001, 2'h0);
      mon <= 3'h5;
      cyc(4);
      chk({fail_pin, lock_pin}, 2'h3, "bad frequency");
      mon <= 3'h7;
      cyc(4);
      chk({fail_pin, lock_pin}, 2'h1, "reference good");
      // pins disabled hold low whatever the status
      wr(gsp_pkg::OFF_CTRL, 32'h0000_0001, gsp_pkg::RESP_OKAY);
      mon <= 3'h3;
      cyc(4);
      chk({fail_pin, lock_pin}, 2'h0, "pins disabled");
      mon <= 3'h7;
      wr(gsp_pkg::OFF_IRQCFG, 32'h0000_0000, gsp_pkg::RESP_OKAY);
      wr(gsp_pkg::OFF_IRQST, 32'h0000_0007, gsp_pkg::RESP_OKAY);
      // a masked event latches but does not interrupt
      mon <= 3'h3;
      cyc(4);
      chk(irq_o, 1'b0, "masked event");
      rc(gsp_pkg::OFF_IRQST, 32'h0000_0007, 32'h0000_0005, 2'h0);
      wr(gsp_pkg::OFF_IRQMSK, 32'h0000_0001, gsp_pkg::RESP_OKAY);
      cyc(3);
      chk(irq_o, 1'b1, "unmasked event");
      for (int i = 0; i < 5; i++)
      begin
         wr(gsp_pkg::OFF_IRQCFG, {24'h00_0000, cfg_tab[i]}, gsp_pkg::RESP_OKAY);
         cyc(3);
         chk({irq_los_oe_n, irq_wire}, pin_tab[i], "irq pin asserted");
      end
      mon <= 3'h7;
      wr(gsp_pkg::OFF_IRQST, 32'h0000_0001, gsp_pkg::RESP_OKAY);
      wr(gsp_pkg::OFF_IRQCFG, 32'h0000_0004, gsp_pkg::RESP_OKAY);
      cyc(3);
      chk({irq_o, irq_los_oe_n, irq_wire}, 3'h3, "open drain idle");
      wr(gsp_pkg::OFF_IRQCFG, 32'h0000_0000, gsp_pkg::RESP_OKAY);
      cyc(3);
      chk({irq_los_oe_n, irq_wire}, 2'h1, "push-pull idle");
      // missing-reference mode follows the live monitor
      wr(gsp_pkg::OFF_IRQCFG, 32'h0000_0001, gsp_pkg::RESP_OKAY);
      mon <= 3'h3;
      cyc(3);
      chk({irq_los_oe_n, irq_wire}, 2'h1, "reference lost");
      mon <= 3'h7;
      cyc(3);
      chk({irq_los_oe_n, irq_wire}, 2'h0, "reference back");
      wr(8'h20, 32'h0000_0001, gsp_pkg::RESP_SLVERR);
      rc(8'h20, 32'hFFFF_FFFF, 32'h0000_0000, gsp_pkg::RESP_SLVERR);
      test_done;
   end

   initial
   begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      test_done;
   end
endmodule
